// ===== rtl/tcb_pkg.sv
// Capture buffer controller constants and shared types
// Operation
// - Single-fill hardware trigger starts on falling edge
// - Continuous hardware trigger: rising edge stops capture
// - Stop finishes the current 512-word block
// - Retrigger restarts writing at buffer start
// - Length 1 to 4096 kB, odd raised
// - Parameter code selects X, XY, RT, all
// - Capture rate independent of parameter selection
// - Rate is maximum over two to n
// - Rate query returns rate in hertz
// - Start carries mode and trigger codes
// - Start discards earlier data, fresh capture
// - Stop while armed aborts, trigger ignored
// - Stored samples survive a stop
// - Status: recording, triggered, wrapped bits
// - Armed reads zero, running reads three
// - Wrap bit on single end or overwrite
// - Sticky bits cleared by length or parameter write
// - Progress reports kilobytes written, full if wrapped
// - Text readout returns one, two, four values
// - Binary readout up to 64 kB, error while running
// - Binary reply hash, digit count, length, floats
// - Single-fill ends when buffer filled once
// - Continuous wraps and overwrites until stopped
package tcb_pkg;
	// ****************************************
	// Sizes and limits
	// ****************************************
	localparam int ADDR_W = 20;
	localparam int LEN_W = 21;
	localparam int KB_W = 13;
	localparam int BLK_W = 9;
	localparam int KB_SH = 8;
	localparam logic [KB_W-1:0] LEN_MIN_KB = 13'h0001;
	localparam logic [KB_W-1:0] LEN_MAX_KB = 13'h1000;
	localparam logic [KB_W-1:0] LEN_RST_KB = 13'h0100;
	localparam logic [4:0] RATE_N_MAX = 5'h14;
	localparam logic [6:0] BIN_MAX_KB = 7'h40;
	localparam logic [6:0] BIN_5DIG_KB = 7'h0a;
	localparam logic [2:0] DIG_4 = 3'h4;
	localparam logic [2:0] DIG_5 = 3'h5;
	localparam logic [7:0] HASH_CHAR = 8'h23;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [1:0] CFG_X = 2'h0;
	localparam logic [1:0] CFG_XY = 2'h1;
	localparam logic [1:0] CFG_RT = 2'h2;
	localparam logic [1:0] CFG_ALL = 2'h3;
	localparam logic [2:0] STAT_RUN = 3'h3;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'b0_0001,
		ST_ARMED = 5'b0_0010,
		ST_REC = 5'b0_0100,
		ST_TEXT = 5'b0_1000,
		ST_BIN = 5'b1_0000
	} tcb_state_e;
	typedef struct packed {
		logic start;
		logic start_cont;
		logic start_hw;
		logic stop;
		logic set_len;
		logic [KB_W-1:0] len_kb;
		logic set_cfg;
		logic [1:0] cfg;
		logic set_rate;
		logic [4:0] rate_n;
		logic get_text;
		logic [ADDR_W-1:0] text_idx;
		logic get_bin;
		logic [11:0] bin_off_kb;
		logic [6:0] bin_kb;
	} tcb_cmd_s;
	typedef struct packed {
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] r;
		logic [31:0] th;
	} tcb_smp_s;
	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
	} tcb_wr_s;
	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
	} tcb_rd_s;
	typedef struct packed {
		logic valid;
		logic [2:0] cnt;
		logic [3:0][31:0] w;
	} tcb_txt_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} tcb_byte_s;
endpackage

// ===== rtl/tcb_trig_sync.sv
// Trigger pin synchroniser and edge detector
`timescale 1ns/1ps
module tcb_trig_sync (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Pin
	input wire logic i_pin,
	// Edges
	output logic o_rise,
	output logic o_fall
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else if (i_ce) begin
			meta <= i_pin;
			sync <= meta;
			prev <= sync;
		end
	end

	assign o_rise = i_ce && sync && !prev;
	assign o_fall = i_ce && !sync && prev;
endmodule

// ===== rtl/tcb_capture_ctrl.sv
// Capture buffer controller: acquisition, status and readback
`timescale 1ns/1ps
module tcb_capture_ctrl (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Trigger pin
	input wire logic i_external_trigger_input,
	// Host commands
	input wire tcb_pkg::tcb_cmd_s i_cmd,
	// Sample source
	input wire logic i_sample_stb,
	input wire tcb_pkg::tcb_smp_s i_sample,
	input wire logic [20:0] i_max_rate_hz,
	// Buffer memory
	output tcb_pkg::tcb_wr_s o_wr,
	output tcb_pkg::tcb_rd_s o_rd,
	input wire logic [31:0] i_rd_data,
	// Status and answers
	output logic [2:0] o_status,
	output logic [tcb_pkg::KB_W-1:0] o_len_kb,
	output logic [1:0] o_cfg,
	output logic [20:0] o_rate_hz,
	output logic [tcb_pkg::KB_W-1:0] o_prog_kb,
	output logic o_range_err,
	output tcb_pkg::tcb_txt_s o_text,
	output tcb_pkg::tcb_byte_s o_byte,
	input wire logic i_byte_ready
);
	import tcb_pkg::*;

	tcb_state_e state, next_state;
	logic trig_rise, trig_fall;
	logic cont, hw, retrig, stop_pend, triggered, wrapped;
	logic [KB_W-1:0] len_kb;
	logic [1:0] cfg;
	logic [4:0] rate_n;
	logic [LEN_W-1:0] len_words, written;
	logic [ADDR_W-1:0] wptr, div_cnt, rate_mask, oldest;
	tcb_smp_s smp;
	logic [2:0] wr_left, txt_iss, txt_got, txt_cnt, bin_pos, bin_ndig;
	logic [1:0] wr_k, txt_sh, bin_bi;
	logic sys_rst, clr_cmd, len_ok, bin_ok, cmd_idle, go_rec, smp_take;
	logic wr_go, wr_wrap, blk_end, rec_done, trig_start, rd_q;
	logic txt_start, txt_req, txt_done, bin_start, bin_req, bin_done;
	logic bin_hdr, bin_have, bin_busy, bin_emit, slot;
	logic [ADDR_W-1:0] txt_addr, bin_addr;
	logic [16:0] bin_bytes;
	logic [14:0] bin_left;
	logic [31:0] bin_word;
	logic [7:0] bin_char;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [2:0] par_cnt(input logic [1:0] c);
		case (c)
			CFG_X: par_cnt = 3'h1;
			CFG_ALL: par_cnt = 3'h4;
			default: par_cnt = 3'h2;
		endcase
	endfunction

	function automatic logic [31:0] word_sel(input tcb_smp_s s, input logic [1:0] c,
			input logic [1:0] k);
		logic [1:0] idx;
		idx = (c == CFG_RT) ? k + 2'h2 : k;
		case (idx)
			2'h0: word_sel = s.x;
			2'h1: word_sel = s.y;
			2'h2: word_sel = s.r;
			default: word_sel = s.th;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a,
			input logic [LEN_W-1:0] lw);
		addr_inc = ({1'b0, a} == lw - 21'h1) ? '0 : a + 1'b1;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_mod(input logic [LEN_W:0] v,
			input logic [LEN_W-1:0] lw);
		addr_mod = (v >= {1'b0, lw}) ? ADDR_W'(v - {1'b0, lw}) : ADDR_W'(v);
	endfunction

	function automatic logic [7:0] dec_char(input logic [16:0] v, input logic [2:0] k);
		logic [16:0] p;
		case (k)
			3'h0: p = 17'h1;
			3'h1: p = 17'ha;
			3'h2: p = 17'h64;
			3'h3: p = 17'h3e8;
			default: p = 17'h2710;
		endcase
		dec_char = ASCII_ZERO + 8'((v / p) % 17'ha);
	endfunction

	tcb_trig_sync u_trig (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_pin(i_external_trigger_input),
		.o_rise(trig_rise),
		.o_fall(trig_fall)
	);

	// ****************************************
	// Decode
	// ****************************************
	assign len_words = {len_kb, 8'h00};
	assign len_ok = i_cmd.len_kb >= LEN_MIN_KB && i_cmd.len_kb <= LEN_MAX_KB;
	assign sys_rst = (i_cmd.set_len && len_ok) || i_cmd.set_cfg;
	assign clr_cmd = sys_rst || i_cmd.start;
	assign cmd_idle = state == ST_IDLE && !clr_cmd;
	assign txt_start = cmd_idle && i_cmd.get_text;
	assign bin_ok = state == ST_IDLE && i_cmd.bin_kb != 7'h0 && i_cmd.bin_kb <= BIN_MAX_KB;
	assign bin_start = cmd_idle && bin_ok && i_cmd.get_bin && !i_cmd.get_text;
	assign trig_start = trig_fall && (state == ST_ARMED || (state == ST_IDLE && retrig));
	assign go_rec = next_state == ST_REC && (state != ST_REC || i_cmd.start);
	assign rate_mask = ~({ADDR_W{1'b1}} << rate_n);
	assign smp_take = state == ST_REC && i_sample_stb && (div_cnt & rate_mask) == '0
		&& wr_left == 3'h0;
	assign wr_go = state == ST_REC && wr_left != 3'h0;
	assign wr_wrap = wr_go && {1'b0, wptr} == len_words - 21'h1;
	assign blk_end = wr_go && wptr[BLK_W-1:0] == '1;
	// end at block or buffer end
	assign rec_done = (wr_wrap && !cont) || (blk_end && stop_pend);

	// ****************************************
	// State machine
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (txt_start)
					next_state = ST_TEXT;
				else if (bin_start)
					next_state = ST_BIN;
				else if (trig_start)
					next_state = ST_REC;
			end
			ST_ARMED: begin
				if (i_cmd.stop)
					next_state = ST_IDLE;
				else if (trig_fall)
					next_state = ST_REC;
			end
			ST_REC: begin
				if (rec_done)
					next_state = ST_IDLE;
			end
			ST_TEXT: begin
				if (txt_done)
					next_state = ST_IDLE;
			end
			ST_BIN: begin
				if (bin_done)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if (i_cmd.start)
			next_state = i_cmd.start_hw ? ST_ARMED : ST_REC;
		if (sys_rst)
			next_state = ST_IDLE;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			state <= ST_IDLE;
		else if (i_ce)
			state <= next_state;
	end

	// ****************************************
	// Configuration
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			len_kb <= LEN_RST_KB;
			cfg <= CFG_X;
			rate_n <= '0;
			o_rate_hz <= '0;
		end else if (i_ce) begin
			if (i_cmd.set_len && len_ok)
				len_kb <= i_cmd.len_kb + {12'h0, i_cmd.len_kb[0]};
			if (i_cmd.set_cfg)
				cfg <= i_cmd.cfg;
			if (i_cmd.set_rate && i_cmd.rate_n <= RATE_N_MAX)
				rate_n <= i_cmd.rate_n;
			o_rate_hz <= i_max_rate_hz >> rate_n;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cont <= 1'b0;
			hw <= 1'b0;
			retrig <= 1'b0;
		end else if (i_ce) begin
			if (i_cmd.start) begin
				cont <= i_cmd.start_cont;
				hw <= i_cmd.start_hw;
				retrig <= i_cmd.start_hw;
			end else if (sys_rst || (state == ST_ARMED && i_cmd.stop)) begin
				retrig <= 1'b0;
			end
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			triggered <= 1'b0;
			wrapped <= 1'b0;
		end else if (i_ce) begin
			if (clr_cmd) begin
				triggered <= 1'b0;
				wrapped <= 1'b0;
			end
			if (wr_wrap)
				wrapped <= 1'b1;
			if (go_rec)
				triggered <= 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			stop_pend <= 1'b0;
		else if (i_ce) begin
			if (go_rec || state != ST_REC)
				stop_pend <= 1'b0;
			else if (i_cmd.stop || (cont && hw && trig_rise))
				stop_pend <= 1'b1;
		end
	end

	assign o_status = {wrapped, triggered, state == ST_REC};
	assign o_prog_kb = written[LEN_W-1:KB_SH];
	assign o_len_kb = len_kb;
	assign o_cfg = cfg;

	// ****************************************
	// Write engine
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wptr <= '0;
			written <= '0;
			div_cnt <= '0;
			wr_left <= '0;
			wr_k <= '0;
			smp <= '0;
		end else if (i_ce) begin
			if (go_rec || sys_rst) begin
				wptr <= '0;
				written <= '0;
				div_cnt <= '0;
				wr_left <= '0;
			end else if (state == ST_REC) begin
				if (i_sample_stb)
					div_cnt <= div_cnt + 1'b1;
				if (smp_take) begin
					smp <= i_sample;
					wr_left <= par_cnt(cfg);
					wr_k <= '0;
				end else if (wr_go) begin
					wptr <= addr_inc(wptr, len_words);
					wr_left <= wr_left - 3'h1;
					wr_k <= wr_k + 2'h1;
					if (written != len_words)
						written <= written + 21'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_wr <= '0;
		else if (i_ce) begin
			o_wr.en <= wr_go;
			o_wr.addr <= wptr;
			o_wr.data <= word_sel(smp, cfg, wr_k);
		end
	end

	// ****************************************
	// Text readout
	// ****************************************
	assign oldest = (wrapped && cont) ? wptr : '0;
	assign txt_sh = (cfg == CFG_X) ? 2'h0 : (cfg == CFG_ALL) ? 2'h2 : 2'h1;
	assign txt_req = state == ST_TEXT && txt_iss != txt_cnt;
	assign txt_done = state == ST_TEXT && txt_got == txt_cnt;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			txt_addr <= '0;
			txt_iss <= '0;
			txt_got <= '0;
			txt_cnt <= '0;
			o_text <= '0;
		end else if (i_ce) begin
			o_text.valid <= txt_done;
			if (txt_start) begin
				txt_addr <= addr_mod({2'b00, oldest} + ({2'b00, i_cmd.text_idx} << txt_sh),
					len_words);
				txt_iss <= '0;
				txt_got <= '0;
				txt_cnt <= par_cnt(cfg);
				o_text.cnt <= par_cnt(cfg);
			end
			if (txt_req) begin
				txt_addr <= addr_inc(txt_addr, len_words);
				txt_iss <= txt_iss + 3'h1;
			end
			if (state == ST_TEXT && rd_q) begin
				o_text.w[txt_got[1:0]] <= i_rd_data;
				txt_got <= txt_got + 3'h1;
			end
		end
	end

	// ****************************************
	// Binary block readout
	// ****************************************
	assign slot = !o_byte.valid || i_byte_ready;
	assign bin_emit = state == ST_BIN && slot && (bin_hdr || bin_have);
	assign bin_req = state == ST_BIN && !bin_have && !bin_busy && bin_left != '0;
	assign bin_done = state == ST_BIN && !bin_hdr && !bin_have && !bin_busy
		&& bin_left == '0;

	always_comb begin
		if (!bin_hdr)
			bin_char = 8'(bin_word >> {bin_bi, 3'b000});
		else if (bin_pos == 3'h0)
			bin_char = HASH_CHAR;
		else if (bin_pos == 3'h1)
			bin_char = ASCII_ZERO + {5'h0, bin_ndig};
		else
			bin_char = dec_char(bin_bytes, 3'(bin_ndig + 3'h1 - bin_pos));
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bin_hdr <= 1'b0;
			bin_pos <= '0;
			bin_ndig <= '0;
			bin_bytes <= '0;
			bin_left <= '0;
			bin_addr <= '0;
			bin_word <= '0;
			bin_bi <= '0;
			bin_have <= 1'b0;
			bin_busy <= 1'b0;
		end else if (i_ce) begin
			if (bin_start) begin
				bin_hdr <= 1'b1;
				bin_pos <= '0;
				bin_ndig <= (i_cmd.bin_kb >= BIN_5DIG_KB) ? DIG_5 : DIG_4;
				bin_bytes <= {i_cmd.bin_kb, 10'h000};
				bin_left <= {i_cmd.bin_kb, 8'h00};
				bin_addr <= addr_mod({2'b00, i_cmd.bin_off_kb, 8'h00}, len_words);
				bin_bi <= '0;
				bin_have <= 1'b0;
				bin_busy <= 1'b0;
			end
			if (bin_emit && bin_hdr) begin
				bin_pos <= bin_pos + 3'h1;
				if (bin_pos == bin_ndig + 3'h1)
					bin_hdr <= 1'b0;
			end
			if (bin_emit && !bin_hdr) begin
				bin_bi <= bin_bi + 2'h1;
				if (bin_bi == 2'h3) begin
					bin_have <= 1'b0;
					bin_left <= bin_left - 15'h1;
				end
			end
			if (bin_req) begin
				bin_busy <= 1'b1;
				bin_addr <= addr_inc(bin_addr, len_words);
			end
			if (state == ST_BIN && rd_q && bin_busy) begin
				bin_word <= i_rd_data;
				bin_have <= 1'b1;
				bin_busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_byte <= '0;
		else if (i_ce) begin
			if (bin_emit) begin
				o_byte.valid <= 1'b1;
				o_byte.data <= bin_char;
			end else if (i_byte_ready) begin
				o_byte.valid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read port and errors
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd <= '0;
			rd_q <= 1'b0;
			o_range_err <= 1'b0;
		end else if (i_ce) begin
			o_rd.en <= txt_req || bin_req;
			o_rd.addr <= txt_req ? txt_addr : bin_addr;
			rd_q <= o_rd.en;
			o_range_err <= (i_cmd.get_bin && !bin_ok) || (i_cmd.get_text && state != ST_IDLE)
				|| (i_cmd.set_len && !len_ok) || (i_cmd.set_rate && i_cmd.rate_n > RATE_N_MAX);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_ARM_TRIG: assert property (
		i_ce && state == ST_ARMED && trig_fall && !i_cmd.stop && !clr_cmd
		|=> state == ST_REC && o_status == STAT_RUN && wptr == '0)
		else $error("armed trigger did not start capture");
	AST_CONT_RISE: assert property (
		i_ce && state == ST_REC && cont && hw && trig_rise && !clr_cmd
		|=> stop_pend || state == ST_IDLE)
		else $error("rising trigger did not stop continuous capture");
	AST_STOP_BLOCK: assert property (
		(i_ce && state == ST_REC && !clr_cmd) ##1 state == ST_IDLE |-> wptr[BLK_W-1:0] == '0)
		else $error("capture ended off a block boundary");
	AST_RETRIG: assert property (
		i_ce && trig_start && state == ST_IDLE && !clr_cmd && !i_cmd.get_text && !i_cmd.get_bin
		|=> state == ST_REC && wptr == '0 && written == '0)
		else $error("retrigger did not restart at buffer start");
	AST_LEN_EVEN: assert property (
		i_ce && i_cmd.set_len && len_ok
		|=> len_kb[0] == 1'b0 && len_kb - $past(i_cmd.len_kb) <= 13'h1)
		else $error("buffer length not rounded up to even");
	AST_ABORT: assert property (
		i_ce && state == ST_ARMED && i_cmd.stop && !clr_cmd |=> state == ST_IDLE && !retrig)
		else $error("stop while armed did not abort");
	AST_ARMED_ZERO: assert property (
		state == ST_ARMED |-> o_status == 3'h0)
		else $error("status not zero while armed");
	AST_STICKY: assert property (
		$fell(wrapped) || $fell(triggered) |-> $past(clr_cmd))
		else $error("sticky status bit cleared without reset");
	AST_BIN_BUSY: assert property (
		i_ce && i_cmd.get_bin && state == ST_REC |=> o_range_err)
		else $error("binary readout while running not refused");
	AST_HASH: assert property (
		i_ce && bin_start && !o_byte.valid |-> ##[1:4] o_byte.valid && o_byte.data == HASH_CHAR)
		else $error("binary reply did not open with hash");
	AST_SINGLE_END: assert property (
		i_ce && wr_wrap && !cont && !clr_cmd |=> state == ST_IDLE && wrapped)
		else $error("single fill did not end at buffer end");

	COV_ARMED_REC: cover property (state == ST_ARMED ##1 state == ST_REC);
	COV_STOP_DRAIN: cover property (stop_pend ##[1:600] state == ST_IDLE);
	COV_BIN_DONE: cover property (bin_done);
endmodule

// ===== sim/tcb_mem_model.sv
// Capture buffer memory model with one-cycle read
`timescale 1ns/1ps
module tcb_mem_model (
	// Clock
	input wire logic i_clk,
	// Write and read ports
	input wire tcb_pkg::tcb_wr_s i_wr,
	input wire tcb_pkg::tcb_rd_s i_rd,
	output logic [31:0] o_rd_data
);
	import tcb_pkg::*;
	logic [31:0] mem [0:4095];
	initial o_rd_data = 32'h0000_0000;
	always @(posedge i_clk) begin
		if (i_wr.en === 1'b1) begin
			mem[i_wr.addr[11:0]] <= i_wr.data;
		end
		if (i_rd.en === 1'b1) begin
			o_rd_data <= mem[i_rd.addr[11:0]];
		end else begin
			o_rd_data <= ~o_rd_data;
		end
	end
endmodule

// ===== sim/test_tcb_capture_ctrl.sv
// Testbench for the capture buffer controller
`timescale 1ns/1ps
module test_tcb_capture_ctrl;
	import tcb_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic clk, rst_n, pin, stb, rdy, err, ce;
	tcb_cmd_s c, cmd;
	tcb_smp_s smp;
	tcb_wr_s wr;
	tcb_rd_s rd;
	tcb_txt_s txt;
	tcb_byte_s byt;
	logic [31:0] rd_data, first_data;
	logic [2:0] stat;
	logic [KB_W-1:0] len, prog;
	logic [1:0] cfg;
	logic [20:0] rate;
	logic [ADDR_W-1:0] first_addr;
	logic [7:0] b;
	int fail_count, num_checks, wr_cnt, cyc;

	tcb_capture_ctrl tcb_capture_ctrl_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_external_trigger_input(pin), .i_cmd(cmd), .i_sample_stb(stb), .i_sample(smp),
		.i_max_rate_hz(21'h1_312d), .o_wr(wr), .o_rd(rd), .i_rd_data(rd_data),
		.o_status(stat), .o_len_kb(len), .o_cfg(cfg), .o_rate_hz(rate), .o_prog_kb(prog),
		.o_range_err(err), .o_text(txt), .o_byte(byt), .i_byte_ready(rdy));
	tcb_mem_model tcb_mem_model_i (.i_clk(clk), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Sample source, sink stalls, write monitor
	always @(posedge clk) begin
		cyc <= cyc + 1;
		stb <= #1 (cyc % 6 == 0);
		smp <= #1 {8'ha1, cyc[23:0], 8'ha2, cyc[23:0], 8'ha3, cyc[23:0], 8'ha4, cyc[23:0]};
		rdy <= #1 (cyc % 3 != 0);
		if (wr.en === 1'b1) begin
			if (wr_cnt == 0) begin
				first_addr = wr.addr;
				first_data = wr.data;
			end
			wr_cnt++;
		end
	end
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic send();
		@(posedge clk) #1 cmd = c;
		@(posedge clk) #1 cmd = '0;
		c = '0;
	endtask
	task automatic wait_stat(input logic [2:0] s, input int lim);
		for (int n = 0; n < lim && stat !== s; n++) @(posedge clk) #1;
		@(posedge clk) #1;
	endtask
	task automatic get_text();
		c.get_text = 1'b1;
		send();
		for (int n = 0; n < 20 && txt.valid !== 1'b1; n++) @(posedge clk) #1;
	endtask
	task automatic get_byte();
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (byt.valid === 1'b1 && rdy === 1'b1) break;
		end
		b = byt.data;
		#1;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_rate();
		@(posedge clk) #1;
		check("len", len, 32'h0000_0100);
		check("stat", stat, 32'h0);
		check("rate", rate, 32'h0001_312d);
		c.set_rate = 1'b1;
		c.rate_n = 5'h04;
		send();
		@(posedge clk) #1;
		check("rate", rate, 32'h0000_1312);
		c.set_rate = 1'b1;
		c.rate_n = 5'h15;
		send();
		check("rate_err", err, 32'h1);
		c.set_rate = 1'b1;
		send();
	endtask
	task automatic t_len();
		c.set_len = 1'b1;
		c.len_kb = 13'h1001;
		send();
		check("len_err", err, 32'h1);
		c.set_len = 1'b1;
		c.len_kb = 13'h1000;
		send();
		check("len", len, 32'h0000_1000);
		c.set_len = 1'b1;
		c.len_kb = 13'h0001;
		send();
		check("len", len, 32'h0000_0002);
	endtask
	task automatic t_single();
		logic [7:0] tops [4] = '{8'ha1, 8'ha1, 8'ha3, 8'ha1};
		logic [2:0] cnts [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
		for (int k = 0; k < 4; k++) begin
			c.set_cfg = 1'b1;
			c.cfg = 2'(k);
			send();
			check("cfg", cfg, 32'(k));
			check("clr_stat", stat, 32'h0);
			wr_cnt = 0;
			c.start = 1'b1;
			send();
			check("run_stat", stat, 32'h3);
			wait_stat(3'h6, 4000);
			check("end_stat", stat, 32'h6);
			check("words", wr_cnt, 32'h0000_0200);
			check("prog", prog, 32'h2);
			check("addr0", first_addr, 32'h0);
			get_text();
			check("txt_cnt", txt.cnt, cnts[k]);
			check("txt_w0", txt.w[0], first_data);
			check("txt_top", txt.w[0][31:24], tops[k]);
		end
	endtask
	task automatic t_cont_hw();
		c.set_len = 1'b1;
		c.len_kb = 13'h0004;
		send();
		c.start = 1'b1;
		c.start_cont = 1'b1;
		c.start_hw = 1'b1;
		send();
		repeat (5) @(posedge clk) #1;
		check("armed", stat, 32'h0);
		wr_cnt = 0;
		pin = 1'b0;
		wait_stat(3'h3, 10);
		check("trig", stat, 32'h3);
		repeat (60) @(posedge clk) #1;
		c.get_bin = 1'b1;
		c.bin_kb = 7'h01;
		send();
		check("bin_err", err, 32'h1);
		pin = 1'b1;
		repeat (3) @(posedge clk) #1;
		check("fill", stat, 32'h3);
		wait_stat(3'h2, 2000);
		check("stop", stat, 32'h2);
		check("words", wr_cnt, 32'h0000_0200);
		check("prog", prog, 32'h2);
		get_text();
		check("txt_w0", txt.w[0], first_data);
		check("txt_w1", txt.w[1][31:24], 32'h0000_00a2);
		wr_cnt = 0;
		pin = 1'b0;
		wait_stat(3'h3, 10);
		repeat (12) @(posedge clk) #1;
		check("retrig", first_addr, 32'h0);
		c.stop = 1'b1;
		send();
		wait_stat(3'h2, 2000);
		check("words", wr_cnt, 32'h0000_0200);
	endtask
	task automatic t_bin();
		logic [7:0] hdr [6] = '{8'h23, 8'h34, 8'h31, 8'h30, 8'h32, 8'h34};
		pin = 1'b1;
		c.get_bin = 1'b1;
		c.bin_kb = 7'h01;
		send();
		for (int n = 0; n < 1030; n++) begin
			get_byte();
			if (n < 6) check("hdr", b, hdr[n]);
			else if (n < 10) check("payload", b, first_data[8*(n-6) +: 8]);
		end
		repeat (4) @(posedge clk) #1;
		check("bin_done", byt.valid, 32'h0);
	endtask
	task automatic t_stop_armed();
		c.start = 1'b1;
		c.start_hw = 1'b1;
		send();
		c.stop = 1'b1;
		send();
		wr_cnt = 0;
		pin = 1'b0;
		repeat (20) @(posedge clk) #1;
		check("abort", stat, 32'h0);
		check("abort_wr", wr_cnt, 32'h0);
	endtask
	task automatic t_ce_hw();
		pin = 1'b1;
		ce = 1'b0;
		c.set_len = 1'b1;
		c.len_kb = 13'h0008;
		send();
		ce = 1'b1;
		check("ce_len", len, 32'h0000_0004);
		c.start = 1'b1;
		c.start_hw = 1'b1;
		send();
		check("armed1", stat, 32'h0);
		pin = 1'b0;
		wait_stat(3'h3, 10);
		check("trig1", stat, 32'h3);
	endtask
	// ****************************************
	// Run
	// ****************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		pin = 1'b1;
		cmd = '0;
		c = '0;
		stb = 1'b0;
		smp = '0;
		rdy = 1'b0;
		cyc = 0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset_rate();
		t_len();
		t_single();
		t_cont_hw();
		t_bin();
		t_stop_armed();
		t_ce_hw();
		complete_run();
	end
	initial begin
		#1_200_000;
		fail_count++;
		complete_run();
	end
endmodule
